//--- design/tone_setting_pkg.sv
// Purpose: constants and carriers for the tone detector setting control
// Assumes: one clock, synchronous active-low reset
// Notes: rules of operation listed below
// Operation
// - controlled mode: five-bit gain code n gives n dB, 0 to 27 dB
// - controlled mode: word lsb one picks 12 kHz, zero picks 16 kHz
// - word shifted msb first: gain msb first, system select bit last
// - output enable high tristates; else select packet/tone, preset/serial
package tone_setting_pkg;
   localparam int WORD_W         = 6;
   localparam int GAIN_W         = 5;
   localparam int GAIN_MSB_POS   = 5;
   localparam int GAIN_LSB_POS   = 1;
   localparam int SYS_SEL_POS    = 0;
   localparam int CHANNELS       = 2;
   localparam logic [GAIN_W-1:0] GAIN_MAX_CODE = 5'h1b;
   localparam logic [WORD_W-1:0] WORD_RESET    = 6'h00;
   localparam logic [2:0]        BIT_CNT_W0    = 3'h0;

   typedef struct packed {
      logic             tristate;
      logic             tone_follower;
      logic             preset_sens;
      logic             sys_12k;
      logic [GAIN_W-1:0] gain_db;
      logic             gain_forbidden;
   } chan_cfg_t;

   typedef struct packed {
      logic sclk;
      logic sdata;
      logic latch;
   } serial_t;
endpackage

//--- design/setting_store.sv
`timescale 1ns/10ps
// Purpose: per-channel store of complete setting words
// Assumes: write strobe one cycle, registered read data
// Notes: read data follows one cycle after the write
module setting_store #(
   parameter int CH = 2,
   parameter int W  = 6
) (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_resetn,
   // write side
   input  wire logic              i_we,
   input  wire logic [CH-1:0]     i_sel,
   input  wire logic [W-1:0]      i_word,
   // read side
   output logic      [CH*W-1:0]   o_words
);
   typedef struct packed {
      logic [CH*W-1:0] mem;
   } store_state_t;
   store_state_t st_reg, st_next;

   always_comb begin
      st_next = st_reg;
      for (int c = 0; c < CH; c++) begin
         if (i_we && i_sel[c]) begin
            st_next.mem[c*W +: W] = i_word;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_words = st_reg.mem;
endmodule

//--- design/tone_detector_setting_control.sv
`timescale 1ns/10ps
// Purpose: serial setting load and mode decode for a two-channel detector
// Assumes: serial pins and mode pins are asynchronous to i_clk
// Notes: word is taken on latch rise after six or more clocked bits
module tone_detector_setting_control #(
   parameter int CHANNELS = tone_setting_pkg::CHANNELS
) (
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_resetn,
   // serial setting interface
   input  wire logic                  i_serial_clk,
   input  wire logic                  i_serial_data,
   input  wire logic [CHANNELS-1:0]   i_chan_load,
   // mode pins
   input  wire logic                  i_system_select,
   input  wire logic                  i_preset_level,
   input  wire logic                  i_output_select,
   input  wire logic                  i_output_enable,
   // per-channel configuration to the analog side
   output tone_setting_pkg::chan_cfg_t o_cfg [CHANNELS]
);
   localparam int W  = tone_setting_pkg::WORD_W;
   localparam int GW = tone_setting_pkg::GAIN_W;

   // refused at elaboration: the load pins are sized per channel
   if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
      $error("channel count out of range");
   end

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [1:0]          sclk_s;
      logic [1:0]          sdat_s;
      logic [1:0]          sys_s;
      logic [1:0]          pre_s;
      logic [1:0]          osel_s;
      logic [1:0]          oen_s;
      logic [2*CHANNELS-1:0] ld_s;
      logic                sclk_d;
      logic [CHANNELS-1:0] ld_d;
      logic [W-1:0]        shift;
      logic [2:0]          cnt;
      logic                we;
      logic [CHANNELS-1:0] we_sel;
   } ctl_state_t;
   ctl_state_t st_reg, st_next;

   tone_setting_pkg::chan_cfg_t cfg_reg  [CHANNELS];
   tone_setting_pkg::chan_cfg_t cfg_next [CHANNELS];

   logic [CHANNELS*W-1:0] words;
   logic [CHANNELS-1:0]   ld_now;

   setting_store #(
      .CH (CHANNELS),
      .W  (W)
   ) u_store (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_we     (st_reg.we),
      .i_sel    (st_reg.we_sel),
      .i_word   (st_reg.shift),
      .o_words  (words)
   );

   // ****************************************
   // serial shift and load
   // ****************************************
   always_comb begin
      st_next = st_reg;
      st_next.sclk_s = {st_reg.sclk_s[0], i_serial_clk};
      st_next.sdat_s = {st_reg.sdat_s[0], i_serial_data};
      st_next.sys_s  = {st_reg.sys_s[0], i_system_select};
      st_next.pre_s  = {st_reg.pre_s[0], i_preset_level};
      st_next.osel_s = {st_reg.osel_s[0], i_output_select};
      st_next.oen_s  = {st_reg.oen_s[0], i_output_enable};
      for (int c = 0; c < CHANNELS; c++) begin
         st_next.ld_s[2*c +: 2] = {st_reg.ld_s[2*c], i_chan_load[c]};
         ld_now[c] = st_reg.ld_s[2*c+1];
      end
      st_next.sclk_d = st_reg.sclk_s[1];
      st_next.ld_d   = ld_now;
      st_next.we     = 1'b0;
      st_next.we_sel = '0;
      // data enters at the lsb, so the first bit ends up as gain msb
      if (st_reg.sclk_s[1] && !st_reg.sclk_d) begin
         st_next.shift = {st_reg.shift[W-2:0], st_reg.sdat_s[1]};
         if (st_reg.cnt != 3'(W)) begin
            st_next.cnt = st_reg.cnt + 3'h1;
         end
      end
      // a short word is dropped so the old one survives; an overlong word keeps its last six bits
      if (|(ld_now & ~st_reg.ld_d)) begin
         if (st_reg.cnt == 3'(W)) begin
            st_next.we     = 1'b1;
            st_next.we_sel = ld_now & ~st_reg.ld_d;
         end
         st_next.cnt = tone_setting_pkg::BIT_CNT_W0;
      end
   end

   // ****************************************
   // mode decode per channel
   // ****************************************
   for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      logic [W-1:0] wd;
      assign wd = words[c*W +: W];
      always_comb begin
         cfg_next[c].tristate      = st_reg.oen_s[1];
         cfg_next[c].tone_follower = st_reg.osel_s[1];
         cfg_next[c].preset_sens   = st_reg.pre_s[1];
         if (st_reg.pre_s[1]) begin
            cfg_next[c].sys_12k = st_reg.sys_s[1];
            cfg_next[c].gain_db = '0;
            cfg_next[c].gain_forbidden = 1'b0;
         end else begin
            cfg_next[c].sys_12k =
               wd[tone_setting_pkg::SYS_SEL_POS];
            cfg_next[c].gain_db =
               wd[tone_setting_pkg::GAIN_MSB_POS:
                  tone_setting_pkg::GAIN_LSB_POS];
            // codes above 27 dB are illegal; flagged, passed unchanged
            cfg_next[c].gain_forbidden =
               cfg_next[c].gain_db > tone_setting_pkg::GAIN_MAX_CODE;
         end
      end
      always_ff @(posedge i_clk) begin
         if (!i_resetn) begin
            cfg_reg[c] <= '{tristate: 1'b1, default: '0};
         end else begin
            cfg_reg[c] <= cfg_next[c];
         end
      end
      assign o_cfg[c] = cfg_reg[c];
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

//--- testbench/tone_setting_props.sv
// Purpose: port checks for the setting control
// Assumes: mode pins settle within six clock edges
// Notes: word mapping itself is checked by the bench
`timescale 1ns/10ps
module tone_setting_props #(
   parameter int CHANNELS = 2
) (
   input wire logic                        i_clk,
   input wire logic                        i_resetn,
   input wire logic [CHANNELS-1:0]         i_chan_load,
   input wire logic                        i_system_select,
   input wire logic                        i_preset_level,
   input wire logic                        i_output_select,
   input wire logic                        i_output_enable,
   input wire tone_setting_pkg::chan_cfg_t o_cfg [CHANNELS]
);
   // ****
   // properties
   // ****
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   property p_hiz;
      i_output_enable [*6] |-> o_cfg[0].tristate && o_cfg[1].tristate;
   endproperty
   a_hiz: assert property (p_hiz) else $error("outputs not tristated");
   property p_tone;
      (!i_output_enable && i_output_select) [*6]
         |-> !o_cfg[1].tristate && o_cfg[1].tone_follower;
   endproperty
   a_tone: assert property (p_tone) else $error("tone follower missing");
   property p_preset;
      (!i_output_enable && i_preset_level && i_system_select) [*6]
         |-> o_cfg[0].preset_sens && o_cfg[0].sys_12k;
   endproperty
   a_preset: assert property (p_preset) else $error("preset 12k missing");
   // longer than the load latency, so a commit never lands on the last step
   property p_hold;
      (!i_chan_load[0] && !i_preset_level) [*8] |-> $stable(o_cfg[0].gain_db);
   endproperty
   a_hold: assert property (p_hold) else $error("gain moved without load");
   property p_flag;
      o_cfg[0].gain_db <= tone_setting_pkg::GAIN_MAX_CODE
         |-> !o_cfg[0].gain_forbidden;
   endproperty
   a_flag: assert property (p_flag) else $error("valid code flagged");
   c_load: cover property ($rose(i_chan_load[1]));
   c_hiz: cover property (i_output_enable [*6]);
   c_pre: cover property ((i_preset_level && !i_output_enable) [*6]);
endmodule
bind tone_detector_setting_control tone_setting_props #(.CHANNELS(CHANNELS))
   tone_setting_props_i (.i_clk, .i_resetn, .i_chan_load, .i_system_select,
   .i_preset_level, .i_output_select, .i_output_enable, .o_cfg);

//--- testbench/serial_host.sv
// Purpose: host driving the serial setting pins
// Assumes: pins change on the falling clock edge
// Notes: nothing holds the data line after a frame
`timescale 1ns/10ps
module serial_host (
   // clock
   input  wire logic  i_clk,
   // serial pins
   output logic       o_serial_clk,
   output logic       o_serial_data,
   output logic [1:0] o_chan_load
);
   initial begin
      o_serial_clk = 1'b0;
      o_serial_data = 1'b0;
      o_chan_load = 2'h0;
   end
   // ****
   // frame; codes above 27 never sent
   // ****
   // n below six makes a short frame on purpose
   task automatic send(input logic [5:0] w, input int c, d, n);
      for (int b = 5; b > 5 - n; b--) begin // msb first
         o_serial_data = w[b];
         repeat (d) @(negedge i_clk);
         o_serial_clk = 1'b1;
         repeat (d) @(negedge i_clk);
         o_serial_clk = 1'b0;
      end
      o_serial_data = ~o_serial_data;
      repeat (d) @(negedge i_clk);
      o_chan_load[c] = 1'b1;
      repeat (d) @(negedge i_clk);
      o_chan_load[c] = 1'b0;
   endtask
endmodule

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the setting control
// Assumes: serial_host drives the serial pins
// Notes: reference words per channel, start at zero like the reset store
`timescale 1ns/10ps
module tb_top;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic ss = 1'b0, pl = 1'b0, os = 1'b0, oe = 1'b0;
   logic sclk, sdat;
   logic [1:0] load;
   tone_setting_pkg::chan_cfg_t cfg [2];
   logic [5:0] wm [2] = '{6'h00, 6'h00};
   int fails = 0;
   int samples_checked = 0;
   always #20 i_clk = ~i_clk;
   serial_host serial_host_i (.i_clk, .o_serial_clk(sclk),
      .o_serial_data(sdat), .o_chan_load(load));
   tone_detector_setting_control tone_detector_setting_control_i (
      .i_clk, .i_resetn, .i_serial_clk(sclk), .i_serial_data(sdat),
      .i_chan_load(load), .i_system_select(ss), .i_preset_level(pl),
      .i_output_select(os), .i_output_enable(oe), .o_cfg(cfg));
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ****
   // reference compare; tristate hides all but the enable
   // ****
   task automatic chk();
      tone_setting_pkg::chan_cfg_t e, m;
      for (int c = 0; c < 2; c++) begin
         e = {oe, os, pl, pl ? ss : wm[c][0], pl ? 5'h00 : wm[c][5:1], 1'b0};
         m = oe ? 10'h200 : {9'h1ff, !pl};
         samples_checked++;
         if ((cfg[c] & m) !== (e & m)) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, cfg[c] & m, e & m);
         end
      end
   endtask
   initial begin
      int c, n;
      logic [5:0] w;
      c = $urandom(32'h32af);
      repeat (2) @(negedge i_clk);
      i_resetn = 1'b1;
      repeat (8) @(negedge i_clk);
      chk();
      for (int i = 0; i < 16; i++) begin
         c = i % 2;
         w = {5'($urandom_range(27)), 1'($urandom_range(1))};
         if (i < 2) w = i ? 6'h37 : 6'h28;
         n = (i % 5 == 4) ? 3 : 6;
         {ss, pl, os} = 3'($urandom);
         oe = (i % 4 == 3);
         serial_host_i.send(w, c, i[1] ? 7 : 3, n);
         if (n == 6) wm[c] = w;
         repeat (10) @(negedge i_clk);
         chk();
      end
      close_out();
   end
   initial begin
      repeat (6000) @(posedge i_clk);
      fails++;
      close_out();
   end
endmodule
